// *** logic/radio_packet_address_filter_repeater.sv ***
`timescale 1ns/1ps
module radio_packet_address_filter_repeater #(
   parameter int BUF_DEPTH = repeater_pkg::BUF_BYTES
) (
   input  wire logic                clock,
   input  wire logic                rstn,
   input  repeater_pkg::cfg_s       cfg,
   input  wire logic                serInValid,
   input  repeater_pkg::byte_s      serInByte,
   output logic                     serInReady,
   output logic                     radTxValid,
   output repeater_pkg::byte_s      radTxByte,
   input  wire logic                radTxReady,
   input  wire logic                radRxValid,
   input  repeater_pkg::byte_s      radRxByte,
   output logic                     serOutValid,
   output repeater_pkg::byte_s      serOutByte,
   output logic                     repeatBusy
);

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_SER_H,
      TX_SER_L,
      TX_SER_DATA,
      TX_REP_H,
      TX_REP_L,
      TX_REP_DATA
   } tx_state_e;

   typedef enum logic [1:0] {
      RX_H,
      RX_L,
      RX_BODY,
      RX_SKIP
   } rx_state_e;

   tx_state_e                       txState;
   tx_state_e                       next_txState;
   logic                            next_radTxValid;
   repeater_pkg::byte_s             next_radTxByte;
   logic                            next_serInReady;
   logic                            free;
   logic                            serTake;

   rx_state_e                       rxState;
   logic [repeater_pkg::BYTE_W-1:0] hiHold;
   logic [repeater_pkg::ADDR_W-1:0] rxAddr;
   logic                            hitPrimary;
   logic                            hitSecondary;
   logic                            matchSecondary;
   logic                            pendValid;
   repeater_pkg::byte_s             pend;

   logic                            txOn;
   logic                            rxOn;
   logic                            repeaterOn;

   logic                            wrValid;
   repeater_pkg::byte_s             wrByte;
   logic                            rdValid;
   logic                            rdValidEff;
   repeater_pkg::byte_s             rdByte;
   logic                            rdSel;
   logic                            rdReady;
   logic [repeater_pkg::ADDR_W-1:0] repAddr;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // Routing owns the addressing when on, so both enables are forced off
   assign txOn       = cfg.txAddrOn && !cfg.routing;
   assign rxOn       = cfg.rxAddrOn && !cfg.routing;
   assign repeaterOn = cfg.repeater;

   assign rxAddr       = {hiHold, radRxByte.data};
   assign hitPrimary   = (rxAddr == cfg.primaryReceiveAddress);
   assign hitSecondary = (rxAddr == cfg.secondaryReceiveAddress);

   // Primary wins when both receive addresses are equal
   assign repAddr = rdSel ? cfg.secondaryTransmitAddress
                          : cfg.primaryTransmitAddress;

   assign rdValidEff = rdValid && repeaterOn;
   assign free       = !radTxValid || radTxReady;
   assign serTake    = serInValid && serInReady;

   repeat_packet_buffer #(
      .DEPTH   (BUF_DEPTH)
   ) u_buffer (
      .clock   (clock),
      .rstn    (rstn),
      .wrValid (wrValid),
      .wrByte  (wrByte),
      .wrSel   (matchSecondary),
      .rdValid (rdValid),
      .rdByte  (rdByte),
      .rdSel   (rdSel),
      .rdReady (rdReady)
   );

   // Transmit path: one output register; repeats take priority at packet start
   always_comb begin
      next_txState    = txState;
      next_radTxValid = radTxValid && !radTxReady;
      next_radTxByte  = radTxByte;
      rdReady         = 1'b0;
      case (txState)
         TX_IDLE: begin
            if (rdValidEff) begin
               next_txState = txOn ? TX_REP_H : TX_REP_DATA;
            end else if (serInValid) begin
               next_txState = txOn ? TX_SER_H : TX_SER_DATA;
            end
         end
         TX_SER_H: begin
            if (free) begin
               next_radTxValid = 1'b1;
               next_radTxByte  = repeater_pkg::mkByte(1'b0,
                  repeater_pkg::hiByte(cfg.primaryTransmitAddress));
               next_txState    = TX_SER_L;
            end
         end
         TX_SER_L: begin
            if (free) begin
               next_radTxValid = 1'b1;
               next_radTxByte  = repeater_pkg::mkByte(1'b0,
                  repeater_pkg::loByte(cfg.primaryTransmitAddress));
               next_txState    = TX_SER_DATA;
            end
         end
         TX_SER_DATA: begin
            if (serTake) begin
               next_radTxValid = 1'b1;
               next_radTxByte  = serInByte;
               if (serInByte.last) begin
                  next_txState = TX_IDLE;
               end
            end
         end
         TX_REP_H: begin
            if (free) begin
               next_radTxValid = 1'b1;
               next_radTxByte  = repeater_pkg::mkByte(1'b0,
                  repeater_pkg::hiByte(repAddr));
               next_txState    = TX_REP_L;
            end
         end
         TX_REP_L: begin
            if (free) begin
               next_radTxValid = 1'b1;
               next_radTxByte  = repeater_pkg::mkByte(1'b0,
                  repeater_pkg::loByte(repAddr));
               next_txState    = TX_REP_DATA;
            end
         end
         TX_REP_DATA: begin
            if (free && rdValid) begin
               next_radTxValid = 1'b1;
               next_radTxByte  = rdByte;
               rdReady         = 1'b1;
               if (rdByte.last) begin
                  next_txState = TX_IDLE;
               end
            end
         end
         default: begin
            next_txState = TX_IDLE;
         end
      endcase
      // Ready is a flop, so it only rises once the output register is empty
      next_serInReady = (next_txState == TX_SER_DATA) && !next_radTxValid;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         txState    <= TX_IDLE;
         radTxValid <= 1'b0;
         radTxByte  <= '0;
         serInReady <= 1'b0;
      end else begin
         txState    <= next_txState;
         radTxValid <= next_radTxValid;
         radTxByte  <= next_radTxByte;
         serInReady <= next_serInReady;
      end
   end

   // Receive path: filters toward the serial side and feeds the repeat buffer.
   // The kept-address case emits two bytes for one, so radio bytes must be
   // at least two cycles apart.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rxState        <= RX_H;
         hiHold         <= '0;
         matchSecondary <= 1'b0;
         pendValid      <= 1'b0;
         pend           <= '0;
         serOutValid    <= 1'b0;
         serOutByte     <= '0;
         wrValid        <= 1'b0;
         wrByte         <= '0;
      end else begin
         serOutValid <= 1'b0;
         wrValid     <= 1'b0;
         if (pendValid) begin
            serOutValid <= 1'b1;
            serOutByte  <= pend;
            pendValid   <= 1'b0;
         end
         if (radRxValid) begin
            case (rxState)
               RX_H: begin
                  if (rxOn) begin
                     hiHold <= radRxByte.data;
                     if (!radRxByte.last) begin
                        rxState <= RX_L;
                     end
                  end else begin
                     serOutValid    <= 1'b1;
                     serOutByte     <= radRxByte;
                     wrValid        <= repeaterOn;
                     wrByte         <= radRxByte;
                     matchSecondary <= 1'b0;
                     if (!radRxByte.last) begin
                        rxState <= RX_BODY;
                     end
                  end
               end
               RX_L: begin
                  if (hitPrimary || hitSecondary) begin
                     matchSecondary <= !hitPrimary;
                     if (cfg.keepMatchedAddressOnOutput) begin
                        serOutValid <= 1'b1;
                        serOutByte  <= repeater_pkg::mkByte(1'b0, hiHold);
                        pendValid   <= 1'b1;
                        pend        <= radRxByte;
                     end
                     // Address stays out of the repeat buffer in both cases
                     rxState <= radRxByte.last ? RX_H : RX_BODY;
                  end else begin
                     rxState <= radRxByte.last ? RX_H : RX_SKIP;
                  end
               end
               RX_BODY: begin
                  serOutValid <= 1'b1;
                  serOutByte  <= radRxByte;
                  wrValid     <= repeaterOn;
                  wrByte      <= radRxByte;
                  if (radRxByte.last) begin
                     rxState <= RX_H;
                  end
               end
               RX_SKIP: begin
                  if (radRxByte.last) begin
                     rxState <= RX_H;
                  end
               end
               default: begin
                  rxState <= RX_H;
               end
            endcase
         end
      end
   end

   assign repeatBusy = rdValid;

   a_serial_primary_addr: assert property (
      txState == TX_SER_H && free
      |=> radTxValid && radTxByte.data == repeater_pkg::hiByte(cfg.primaryTransmitAddress)
      ##1 (txState != TX_SER_L) || radTxValid)
      else $error("serial packet did not start with primary address");

   a_repeat_addr_sel: assert property (
      txState == TX_REP_H && free
      |=> radTxByte.data == repeater_pkg::hiByte(rdSel ? cfg.secondaryTransmitAddress
                                                        : cfg.primaryTransmitAddress))
      else $error("repeat used wrong transmit address");

   a_tx_plain_start: assert property (
      txState == TX_IDLE && !rdValidEff && serInValid && !txOn
      |=> txState == TX_SER_DATA)
      else $error("address inserted with transmit addressing off");

   a_rx_unmatched_drop: assert property (
      rxState == RX_L && radRxValid && rxOn && !hitPrimary && !hitSecondary
      |=> !serOutValid ##1 !serOutValid)
      else $error("unmatched packet reached serial output");

   a_rx_strip_addr: assert property (
      rxState == RX_L && radRxValid && (hitPrimary || hitSecondary)
      && !cfg.keepMatchedAddressOnOutput
      |=> !serOutValid)
      else $error("address bytes not stripped");

   a_rx_keep_addr: assert property (
      rxState == RX_L && radRxValid && (hitPrimary || hitSecondary)
      && cfg.keepMatchedAddressOnOutput
      |=> serOutValid && serOutByte.data == $past(hiHold)
      ##1 serOutValid && serOutByte.data == $past(radRxByte.data, 2))
      else $error("kept address bytes wrong");

   a_rx_pass_through: assert property (
      (rxState == RX_H || rxState == RX_BODY) && radRxValid && !rxOn
      |=> serOutValid && serOutByte == $past(radRxByte))
      else $error("byte not forwarded with receive addressing off");

   a_routing_ignores: assert property (
      cfg.routing && rxState == RX_H && radRxValid
      |=> serOutValid)
      else $error("routing mode still filtered addresses");

   a_repeat_write: assert property (
      repeaterOn && rxState == RX_BODY && radRxValid
      |=> wrValid && wrByte.data == $past(radRxByte.data))
      else $error("payload byte not buffered for repeat");

   c_serial_addressed: cover property (txState == TX_SER_L ##1 txState == TX_SER_DATA);
   c_repeat_sent:      cover property (txState == TX_REP_DATA && rdReady && rdByte.last);
   c_secondary_match:  cover property (rxState == RX_L && radRxValid && !hitPrimary
                                       && hitSecondary);
   c_unmatched:        cover property (rxState == RX_SKIP);

endmodule : radio_packet_address_filter_repeater

// *** logic/repeater_pkg.sv ***
package repeater_pkg;

   localparam int BYTE_W    = 8;
   localparam int ADDR_W    = 16;
   // High address byte starts at this bit
   localparam int HI_LSB    = 8;
   // Largest packet the repeat path holds (1 kB)
   localparam int BUF_BYTES = 1024;

   typedef struct packed {
      logic              last;
      logic [BYTE_W-1:0] data;
   } byte_s;

   typedef struct packed {
      logic              routing;
      logic              repeater;
      logic              txAddrOn;
      logic              rxAddrOn;
      logic              keepMatchedAddressOnOutput;
      logic [ADDR_W-1:0] primaryTransmitAddress;
      logic [ADDR_W-1:0] secondaryTransmitAddress;
      logic [ADDR_W-1:0] primaryReceiveAddress;
      logic [ADDR_W-1:0] secondaryReceiveAddress;
   } cfg_s;

   function automatic logic [BYTE_W-1:0] hiByte(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:HI_LSB];
   endfunction : hiByte

   function automatic logic [BYTE_W-1:0] loByte(input logic [ADDR_W-1:0] a);
      return a[HI_LSB-1:0];
   endfunction : loByte

   function automatic byte_s mkByte(input logic last, input logic [BYTE_W-1:0] d);
      byte_s b;
      b.last = last;
      b.data = d;
      return b;
   endfunction : mkByte

endpackage : repeater_pkg

// *** logic/repeat_packet_buffer.sv ***
`timescale 1ns/1ps
module repeat_packet_buffer #(
   parameter int DEPTH = repeater_pkg::BUF_BYTES
) (
   input  wire logic                clock,
   input  wire logic                rstn,
   input  wire logic                wrValid,
   input  repeater_pkg::byte_s      wrByte,
   input  wire logic                wrSel,
   output logic                     rdValid,
   output repeater_pkg::byte_s      rdByte,
   output logic                     rdSel,
   input  wire logic                rdReady
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [repeater_pkg::BYTE_W-1:0] mem [DEPTH];
   logic [CW-1:0] wrCount;
   logic [AW-1:0] rdPtr;
   logic [AW-1:0] lastIdx;
   logic          holding;
   logic          skip;
   logic          ovf;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   always_ff @(posedge clock) begin
      if (wrValid && !holding && !skip && wrCount != FULL) begin
         mem[wrCount[AW-1:0]] <= wrByte.data;
      end
   end

   // Only one packet is held; anything arriving while it waits is not repeated
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         holding <= 1'b0;
         skip    <= 1'b0;
         ovf     <= 1'b0;
         wrCount <= '0;
         rdPtr   <= '0;
         lastIdx <= '0;
         rdSel   <= 1'b0;
      end else begin
         if (holding && rdReady) begin
            rdPtr <= rdPtr + 1'b1;
            if (rdPtr == lastIdx) begin
               holding <= 1'b0;
            end
         end
         if (wrValid) begin
            if (skip || holding) begin
               skip <= !wrByte.last;
            end else begin
               if (wrCount == FULL) begin
                  ovf <= 1'b1;
               end else begin
                  wrCount <= wrCount + 1'b1;
               end
               if (wrByte.last) begin
                  wrCount <= '0;
                  ovf     <= 1'b0;
                  if (!ovf && wrCount != FULL) begin
                     holding <= 1'b1;
                     lastIdx <= wrCount[AW-1:0];
                     rdPtr   <= '0;
                     rdSel   <= wrSel;
                  end
               end
            end
         end
      end
   end

   assign rdValid     = holding;
   assign rdByte.data = mem[rdPtr];
   assign rdByte.last = (rdPtr == lastIdx);

   a_overflow_dropped: assert property (
      wrValid && wrByte.last && !skip && !holding && (ovf || wrCount == FULL)
      |=> !holding)
      else $error("overflowed packet was queued for repeat");

   a_commit_repeat: assert property (
      wrValid && wrByte.last && !skip && !holding && !ovf && wrCount != FULL
      |=> holding && rdPtr == '0 && rdSel == $past(wrSel))
      else $error("complete packet not queued for repeat");

   c_overflow: cover property (wrValid && wrCount == FULL && !holding);

endmodule : repeat_packet_buffer

// *** verif/radio_far_end.sv ***
`timescale 1ns/1ps
module radio_far_end (
   input  wire logic           clock,
   input  wire logic           stall,
   input  wire logic           radTxValid,
   input  repeater_pkg::byte_s radTxByte,
   output logic                radTxReady,
   output logic                radRxValid,
   output repeater_pkg::byte_s radRxByte
);
   repeater_pkg::byte_s got[$];
   logic                next_radTxReady;

   initial begin
      radTxReady = 1'b1;
      radRxValid = 1'b0;
      radRxByte  = '0;
   end

   // Outputs are registered, so the values seen here are those of the next rising edge
   always @(negedge clock) begin
      next_radTxReady = stall ? ~radTxReady : 1'b1;
      if (radTxValid === 1'b1 && next_radTxReady)
         got.push_back(radTxByte);
      radTxReady <= next_radTxReady;
   end

   // One-cycle pulses, an idle cycle between; idle data is scrambled, not held
   task automatic sendRad(input logic [7:0] d[$]);
      foreach (d[i]) begin
         @(negedge clock);
         radRxValid <= 1'b1;
         radRxByte  <= '{i == d.size() - 1, d[i]};
         @(negedge clock);
         radRxValid <= 1'b0;
         radRxByte  <= ~radRxByte;
      end
   endtask : sendRad
endmodule : radio_far_end

// *** verif/radio_packet_address_filter_repeater_bench.sv ***
`timescale 1ns/1ps
module radio_packet_address_filter_repeater_bench;
   localparam int          DEPTH = 8;
   localparam logic [15:0] PTX   = 16'h12ab;
   localparam logic [15:0] STX   = 16'hcd34;
   localparam logic [15:0] PRX   = 16'h5e01;
   localparam logic [15:0] SRX   = 16'h00f7;

   logic                clock;
   logic                rstn;
   logic                stall;
   logic                busySeen;
   logic                readyEarly;
   repeater_pkg::cfg_s  cfg;
   logic                serInValid;
   repeater_pkg::byte_s serInByte;
   logic                serInReady;
   logic                radTxValid;
   repeater_pkg::byte_s radTxByte;
   logic                radTxReady;
   logic                radRxValid;
   repeater_pkg::byte_s radRxByte;
   logic                serOutValid;
   repeater_pkg::byte_s serOutByte;
   logic                repeatBusy;
   repeater_pkg::byte_s serGot[$];
   logic [7:0]          none[$];
   logic [7:0]          pl[$];
   int                  errTotal;
   int                  nChecks;

   radio_packet_address_filter_repeater #(.BUF_DEPTH(DEPTH)) uut (
      .clock(clock), .rstn(rstn), .cfg(cfg), .serInValid(serInValid),
      .serInByte(serInByte), .serInReady(serInReady), .radTxValid(radTxValid),
      .radTxByte(radTxByte), .radTxReady(radTxReady), .radRxValid(radRxValid),
      .radRxByte(radRxByte), .serOutValid(serOutValid), .serOutByte(serOutByte),
      .repeatBusy(repeatBusy));

   radio_far_end far (
      .clock(clock), .stall(stall), .radTxValid(radTxValid), .radTxByte(radTxByte),
      .radTxReady(radTxReady), .radRxValid(radRxValid), .radRxByte(radRxByte));

   always #2 clock = ~clock;

   always @(negedge clock) begin
      if (serOutValid === 1'b1)
         serGot.push_back(serOutByte);
      if (repeatBusy === 1'b1)
         busySeen = 1'b1;
      // Ready may only rise once the radio output register has emptied
      if (serInReady === 1'b1 && radTxValid !== 1'b0)
         readyEarly = 1'b1;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic expectPkt(input string nm, ref repeater_pkg::byte_s q[$],
                            input logic [7:0] e[$]);
      chk(nm, 16'(q.size()), 16'(e.size()));
      foreach (e[i])
         if (i < q.size())
            chk(nm, 16'(q[i]), {7'h0, i == e.size() - 1, e[i]});
      q.delete();
   endtask : expectPkt

   task automatic setCfg(input int rt, rp, tx, rx, kp);
      @(negedge clock);
      cfg      = '{1'(rt), 1'(rp), 1'(tx), 1'(rx), 1'(kp), PTX, STX, PRX, SRX};
      busySeen = 1'b0;
   endtask : setCfg

   // Quiet means no repeat pending and nothing leaving on either side
   task automatic settle;
      int q;
      int n;
      q = 0;
      n = 0;
      while (q < 8 && n < 3000) begin
         @(negedge clock);
         n++;
         if (repeatBusy === 1'b0 && radTxValid === 1'b0 && serOutValid === 1'b0)
            q++;
         else
            q = 0;
      end
   endtask : settle

   task automatic txCase(input string nm, input logic [7:0] d[$], input logic [7:0] e[$]);
      foreach (d[i]) begin
         @(negedge clock);
         serInValid = 1'b1;
         serInByte  = '{i == d.size() - 1, d[i]};
         while (serInReady !== 1'b1)
            @(negedge clock);
      end
      @(negedge clock);
      serInValid = 1'b0;
      serInByte  = ~serInByte;
      settle();
      expectPkt(nm, far.got, e);
      $display("test %s done", nm);
   endtask : txCase

   task automatic rxCase(input string nm, input logic [7:0] d[$], input logic [7:0] es[$],
                         input logic [7:0] er[$]);
      far.sendRad(d);
      settle();
      expectPkt({nm, " serial"}, serGot, es);
      expectPkt({nm, " radio"}, far.got, er);
      $display("test %s done", nm);
   endtask : rxCase

   task automatic conclude;
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   initial begin
      #(20000 * 4);
      errTotal++;
      conclude();
   end

   initial begin
      clock      = 1'b0;
      rstn       = 1'b0;
      stall      = 1'b0;
      busySeen   = 1'b0;
      readyEarly = 1'b0;
      serInValid = 1'b0;
      serInByte  = '0;
      errTotal   = 0;
      nChecks    = 0;
      cfg        = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, PTX, STX, PRX, SRX};
      for (int i = 0; i < DEPTH + 1; i++)
         pl.push_back(8'(8'h40 + i));
      repeat (10) @(negedge clock);
      rstn = 1'b1;
      setCfg(0, 0, 1, 0, 0);
      stall = 1'b1;
      txCase("txaddr", '{8'h01, 8'h02, 8'h03}, '{8'h12, 8'hab, 8'h01, 8'h02, 8'h03});
      stall = 1'b0;
      setCfg(1, 0, 1, 1, 0);
      txCase("routing tx", '{8'h5e, 8'h01, 8'h77}, '{8'h5e, 8'h01, 8'h77});
      rxCase("routing rx", '{8'h99, 8'h98, 8'h42}, '{8'h99, 8'h98, 8'h42}, none);
      setCfg(0, 0, 0, 1, 0);
      txCase("rx only tx", '{8'h33}, '{8'h33});
      rxCase("match primary", '{8'h5e, 8'h01, 8'hd1, 8'hd2}, '{8'hd1, 8'hd2}, none);
      rxCase("match secondary", '{8'h00, 8'hf7, 8'hd3}, '{8'hd3}, none);
      rxCase("mismatch", '{8'h5e, 8'h02, 8'hd4}, none, none);
      rxCase("mismatch high", '{8'h01, 8'h01, 8'hd4}, none, none);
      setCfg(0, 0, 0, 1, 1);
      rxCase("keep", '{8'h00, 8'hf7, 8'hd5}, '{8'h00, 8'hf7, 8'hd5}, none);
      setCfg(0, 0, 0, 0, 0);
      rxCase("rx off", '{8'h5e, 8'h02, 8'hd6}, '{8'h5e, 8'h02, 8'hd6}, none);
      setCfg(0, 1, 1, 1, 0);
      rxCase("rep sec", '{8'h00, 8'hf7, 8'hb1, 8'hb2}, '{8'hb1, 8'hb2},
             '{8'hcd, 8'h34, 8'hb1, 8'hb2});
      chk("busy", 16'(busySeen), 16'h1);
      rxCase("rep pri", '{8'h5e, 8'h01, 8'hb3}, '{8'hb3}, '{8'h12, 8'hab, 8'hb3});
      txCase("rep serial", '{8'hc1}, '{8'h12, 8'hab, 8'hc1});
      // Terminal side prepends the hop chain, first hop leading
      setCfg(0, 1, 0, 1, 0);
      rxCase("chain", '{8'h5e, 8'h01, 8'h0a, 8'h0b, 8'hb4}, '{8'h0a, 8'h0b, 8'hb4},
             '{8'h0a, 8'h0b, 8'hb4});
      setCfg(0, 1, 1, 1, 0);
      rxCase("full", {8'h5e, 8'h01, pl[0:DEPTH-1]}, pl[0:DEPTH-1],
             {8'h12, 8'hab, pl[0:DEPTH-1]});
      setCfg(0, 1, 1, 1, 0);
      rxCase("overflow", {8'h5e, 8'h01, pl}, pl, none);
      chk("overflow busy", 16'(busySeen), 16'h0);
      setCfg(0, 1, 1, 1, 0);
      // Single address pair: both of each kind programmed alike
      cfg.secondaryTransmitAddress = PTX;
      cfg.secondaryReceiveAddress  = PRX;
      rxCase("one pair", '{8'h5e, 8'h01, 8'hb5}, '{8'hb5}, '{8'h12, 8'hab, 8'hb5});
      rxCase("one pair other", '{8'h00, 8'hf7, 8'hb6}, none, none);
      chk("ready busy", 16'(readyEarly), 16'h0);
      conclude();
   end
endmodule : radio_packet_address_filter_repeater_bench
